// >>> ubdt_pkg.sv
// package: descriptor table layout, status fields, handshakes and transaction types
package ubdt_pkg;
  localparam int          UBDT_NUM_DESC    = 64;         // descriptors 0..63
  localparam int          UBDT_IDX_W       = 6;          // descriptor index width
  localparam int          UBDT_RAM_BYTES   = 256;        // largest table in bytes
  localparam int          UBDT_ADDR_W      = 8;          // byte offset in table
  localparam logic [11:0] UBDT_BASE_ADDR   = 12'h400;    // table bank base
  localparam int          UBDT_MIN_BYTES   = 8;          // endpoint 0 in and out
  localparam int          UBDT_NUM_EP      = 16;         // endpoints
  localparam int          UBDT_EP_W        = 4;          // endpoint number width
  // byte position inside one four-byte descriptor
  localparam logic [1:0]  UBDT_OFS_STAT    = 2'h0;
  localparam logic [1:0]  UBDT_OFS_CNT     = 2'h1;
  localparam logic [1:0]  UBDT_OFS_ADRL    = 2'h2;
  localparam logic [1:0]  UBDT_OFS_ADRH    = 2'h3;
  // status byte bit positions
  localparam int          UBDT_BIT_OWNER   = 7;
  localparam int          UBDT_BIT_DTS     = 6;
  localparam int          UBDT_BIT_TOGGLE_CHECK_ENABLE   = 3;
  localparam int          UBDT_BIT_BUFFER_STALL_ENABLE  = 2;
  localparam int          UBDT_PID_LSB     = 2;          // token pid field 5..2
  localparam int          UBDT_CNT_W       = 10;         // byte count width
  localparam logic [9:0]  UBDT_CNT_MAX     = 10'h3FF;    // largest byte count
  localparam logic [7:0]  UBDT_KEEP_MASK   = 8'h40;      // bit 6 not written back

  // transaction kind reported by the link side
  typedef enum logic [1:0] {
    UBDT_TOK_OUT   = 2'b00,
    UBDT_TOK_IN    = 2'b01,
    UBDT_TOK_SETUP = 2'b10,
    UBDT_TOK_NONE  = 2'b11
  } ubdt_tok_t;

  // handshake answered to the host
  typedef enum logic [1:0] {
    UBDT_HS_NONE  = 2'b00,
    UBDT_HS_ACK   = 2'b01,
    UBDT_HS_NAK   = 2'b10,
    UBDT_HS_STALL = 2'b11
  } ubdt_hs_t;

  // completed transaction from the engine datapath
  typedef struct packed {
    ubdt_tok_t             tok;      // token kind
    logic [UBDT_EP_W-1:0]  ep;       // endpoint number
    logic [UBDT_IDX_W-1:0] idx;      // descriptor index used
    logic [3:0]            pid;      // token pid value
    logic                  data1;    // received packet was DATA1
    logic                  err;      // packet carried an error
    logic [9:0]            count;    // bytes moved
  } ubdt_txn_t;

  // result of a transaction
  typedef struct packed {
    ubdt_hs_t             hs;        // handshake
    logic                 done;      // transfer done event
    logic                 stall;     // stall issued event
    logic [UBDT_EP_W-1:0] ep;        // endpoint concerned
  } ubdt_rsp_t;
endpackage : ubdt_pkg

// >>> ubdt_ram.sv
// dual-access byte memory holding the descriptor table
`timescale 1ns/10ps
module ubdt_ram
  import ubdt_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   a_we,
  input  wire logic [UBDT_ADDR_W-1:0] a_addr,
  input  wire logic [7:0]             a_wdata,
  output logic      [7:0]             a_rdata,
  input  wire logic                   b_we,
  input  wire logic [UBDT_ADDR_W-1:0] b_addr,
  input  wire logic [7:0]             b_wdata,
  output logic      [7:0]             b_rdata
);
  // storage has no reset so contents stay undefined until written
  logic [7:0] mem_reg [UBDT_RAM_BYTES];

  // port b wins a same-address write collision
  always_ff @(posedge sys_clk)
  begin
    if (a_we && !(b_we && b_addr == a_addr))
      mem_reg[a_addr] <= a_wdata;
    if (b_we)
      mem_reg[b_addr] <= b_wdata;
  end

  // asynchronous reads, both sides see the table at any time
  assign a_rdata = mem_reg[a_addr];
  assign b_rdata = mem_reg[b_addr];
endmodule : ubdt_ram

// >>> ubdt_core.sv
// descriptor table and engine status handling for the usb device
`timescale 1ns/10ps
module ubdt_core
  import ubdt_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  // processor data-memory port into the table bank
  input  wire logic                   cpu_we,
  input  wire logic [UBDT_ADDR_W-1:0] cpu_addr,
  input  wire logic [7:0]             cpu_wdata,
  output logic      [7:0]             cpu_rdata,
  // endpoint input-enable bits and stall-flag clears from firmware
  input  wire logic [UBDT_NUM_EP-1:0] ep_in_enable,
  input  wire logic [UBDT_NUM_EP-1:0] ep_stall_clear,
  output logic      [UBDT_NUM_EP-1:0] endpoint_stalled_flag,
  // descriptor lookup by the engine datapath
  input  wire logic [UBDT_IDX_W-1:0]  look_idx,
  output logic      [7:0]             look_status,
  // finished transaction from the engine datapath
  input  wire logic                   txn_valid,
  input  wire ubdt_txn_t              txn,
  output logic                        txn_ready,
  output ubdt_rsp_t                   rsp,
  output logic                        rsp_valid
);
  // engine state machine
  typedef enum logic [1:0] {
    UBDT_ST_IDLE  = 2'b00,
    UBDT_ST_READ  = 2'b01,
    UBDT_ST_DECIDE= 2'b10,
    UBDT_ST_WRCNT = 2'b11
  } ubdt_state_t;

  ubdt_state_t               state_reg,  state_next;   // engine state
  ubdt_txn_t                 txn_reg,    txn_next;     // captured transaction
  logic [7:0]                stat_reg,   stat_next;    // status byte snapshot
  ubdt_rsp_t                 rsp_reg,    rsp_next;     // registered answer
  logic                      rspv_reg,   rspv_next;    // answer strobe
  logic [UBDT_NUM_EP-1:0]    stall_reg,  stall_next;   // endpoint stall flags
  logic                      b_we;                     // engine write strobe
  logic [UBDT_ADDR_W-1:0]    b_addr;                   // engine byte address
  logic [7:0]                b_wdata;                  // engine write data
  logic [7:0]                b_rdata;                  // engine read data
  logic                      ep_live;                  // endpoint active
  logic                      toggle_ok;                // toggle matches

  // table memory: processor on port a, engine on port b
  ubdt_ram u_ram (
    .sys_clk (sys_clk),
    .a_we    (cpu_we),
    .a_addr  (cpu_addr),
    .a_wdata (cpu_wdata),
    .a_rdata (cpu_rdata),
    .b_we    (b_we),
    .b_addr  (b_addr),
    .b_wdata (b_wdata),
    .b_rdata (b_rdata)
  );

  // byte address of a descriptor field: four bytes per index
  function automatic logic [UBDT_ADDR_W-1:0] desc_addr(
    input logic [UBDT_IDX_W-1:0] idx,
    input logic [1:0]            ofs
  );
    desc_addr = {idx, ofs};
  endfunction : desc_addr

  // a descriptor behaves as one only if its endpoint is input-enabled
  assign ep_live   = ep_in_enable[txn_reg.ep];
  // expected toggle in bit 6: 1 is DATA1
  assign toggle_ok = (txn_reg.data1 == stat_reg[UBDT_BIT_DTS]);
  assign look_status = (state_reg == UBDT_ST_IDLE) ? b_rdata : stat_reg;
  assign txn_ready = (state_reg == UBDT_ST_IDLE);
  assign rsp       = rsp_reg;
  assign rsp_valid = rspv_reg;
  assign endpoint_stalled_flag = stall_reg;

  // next-state and write-back decisions of the engine
  always_comb
  begin
    state_next = state_reg;
    txn_next   = txn_reg;
    stat_next  = stat_reg;
    rsp_next   = rsp_reg;
    rspv_next  = 1'b0;
    stall_next = stall_reg & ~ep_stall_clear;
    b_we       = 1'b0;
    b_addr     = desc_addr(look_idx, UBDT_OFS_STAT);
    b_wdata    = 8'h00;
    case (state_reg)
      UBDT_ST_IDLE:
      begin
        // take one finished transaction
        if (txn_valid)
        begin
          txn_next   = txn;
          state_next = UBDT_ST_READ;
        end
      end
      UBDT_ST_READ:
      begin
        // snapshot the status byte of the chosen descriptor
        b_addr     = desc_addr(txn_reg.idx, UBDT_OFS_STAT);
        stat_next  = b_rdata;
        state_next = UBDT_ST_DECIDE;
      end
      UBDT_ST_DECIDE:
      begin
        b_addr          = desc_addr(txn_reg.idx, UBDT_OFS_STAT);
        rspv_next       = 1'b1;
        rsp_next.ep     = txn_reg.ep;
        rsp_next.done   = 1'b0;
        rsp_next.stall  = 1'b0;
        rsp_next.hs     = UBDT_HS_NAK;
        state_next      = UBDT_ST_IDLE;
        if (!ep_live || !stat_reg[UBDT_BIT_OWNER])
        begin
          // not engine-owned or endpoint off: refuse
          rsp_next.hs = UBDT_HS_NAK;
        end
        else if (stat_reg[UBDT_BIT_BUFFER_STALL_ENABLE] &&
                 txn_reg.tok != UBDT_TOK_SETUP)
        begin
          // buffer stall: answer stall, descriptor untouched
          rsp_next.hs    = UBDT_HS_STALL;
          rsp_next.stall = 1'b1;
          stall_next[txn_reg.ep] = 1'b1;
        end
        else if (txn_reg.err && txn_reg.tok != UBDT_TOK_IN)
        begin
          // errored packet: nak, ownership kept
          rsp_next.hs = UBDT_HS_NAK;
        end
        else if (txn_reg.tok == UBDT_TOK_OUT &&
                 stat_reg[UBDT_BIT_TOGGLE_CHECK_ENABLE] && !toggle_ok)
        begin
          // toggle mismatch: ack but discard, keep ownership
          rsp_next.hs = UBDT_HS_ACK;
        end
        else
        begin
          // complete: pid and count high bits, owner cleared
          // setup skips the buffer stall and lands here unless refused or errored; the endpoint stall flag is left set
          rsp_next.hs   = (txn_reg.tok == UBDT_TOK_IN) ? UBDT_HS_NONE
                                                       : UBDT_HS_ACK;
          rsp_next.done = 1'b1;
          b_we          = 1'b1;
          b_wdata       = (stat_reg & UBDT_KEEP_MASK) |
                          {2'b00, txn_reg.pid, txn_reg.count[9:8]};
          b_wdata[UBDT_BIT_OWNER] = 1'b0;
          state_next    = UBDT_ST_WRCNT;
        end
      end
      UBDT_ST_WRCNT:
      begin
        // low eight bits of the moved count
        b_we       = 1'b1;
        b_addr     = desc_addr(txn_reg.idx, UBDT_OFS_CNT);
        b_wdata    = txn_reg.count[7:0];
        state_next = UBDT_ST_IDLE;
      end
      default:
      begin
        state_next = UBDT_ST_IDLE;
      end
    endcase
  end

  // register all engine state; memory itself has no reset
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_reg <= UBDT_ST_IDLE;
      txn_reg   <= '0;
      stat_reg  <= 8'h00;
      rsp_reg   <= '0;
      rspv_reg  <= 1'b0;
      stall_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      txn_reg   <= txn_next;
      stat_reg  <= stat_next;
      rsp_reg   <= rsp_next;
      rspv_reg  <= rspv_next;
      stall_reg <= stall_next;
    end
  end

  // stall answer comes with the endpoint flag already raised in the same cycle
  a_stall_sets_flag: assert property (@(posedge sys_clk) disable iff (reset)
    rspv_reg && rsp_reg.stall |-> stall_reg[rsp_reg.ep])
    else $error("stall issued without stalled flag");

  // a done decision starts a two-byte write-back in the same cycle
  sequence s_write_back;
    b_we && b_wdata[UBDT_BIT_OWNER] == 1'b0 ##1 b_we;
  endsequence
  a_done_releases: assert property (@(posedge sys_clk) disable iff (reset)
    state_reg == UBDT_ST_DECIDE && state_next == UBDT_ST_WRCNT
    |-> s_write_back)
    else $error("completion did not release descriptor");

  // stall and done never together
  a_stall_no_done: assert property (@(posedge sys_clk) disable iff (reset)
    rspv_reg |-> !(rsp_reg.stall && rsp_reg.done))
    else $error("stall answer also completed");

  // errored out never completes
  a_err_nak: assert property (@(posedge sys_clk) disable iff (reset)
    state_reg == UBDT_ST_DECIDE && txn_reg.err &&
    txn_reg.tok == UBDT_TOK_OUT && !stat_reg[UBDT_BIT_BUFFER_STALL_ENABLE]
    |=> rspv_reg && rsp_reg.hs == UBDT_HS_NAK && !rsp_reg.done)
    else $error("errored packet not refused");

  // toggle mismatch acks without completing
  a_toggle_drop: assert property (@(posedge sys_clk) disable iff (reset)
    state_reg == UBDT_ST_DECIDE && ep_live && stat_reg[UBDT_BIT_OWNER] &&
    !stat_reg[UBDT_BIT_BUFFER_STALL_ENABLE] && !txn_reg.err &&
    txn_reg.tok == UBDT_TOK_OUT && stat_reg[UBDT_BIT_TOGGLE_CHECK_ENABLE] && !toggle_ok
    |=> rsp_reg.hs == UBDT_HS_ACK && !rsp_reg.done)
    else $error("toggle mismatch mishandled");

  // without toggle check a clean out completes
  a_no_check_done: assert property (@(posedge sys_clk) disable iff (reset)
    state_reg == UBDT_ST_DECIDE && ep_live && stat_reg[UBDT_BIT_OWNER] &&
    !stat_reg[UBDT_BIT_BUFFER_STALL_ENABLE] && !txn_reg.err &&
    txn_reg.tok == UBDT_TOK_OUT && !stat_reg[UBDT_BIT_TOGGLE_CHECK_ENABLE]
    |=> rsp_reg.done && rsp_reg.hs == UBDT_HS_ACK)
    else $error("clean out not completed");

  // disabled endpoint never written by the engine
  a_dead_ep_quiet: assert property (@(posedge sys_clk) disable iff (reset)
    state_reg == UBDT_ST_DECIDE && !ep_live |-> !b_we)
    else $error("write to disabled endpoint descriptor");

  // no stalled flag of any endpoint drops without its clear
  a_stall_holds: assert property (@(posedge sys_clk) disable iff (reset)
    1'b1 |=> (($past(stall_reg) & ~$past(ep_stall_clear) & ~stall_reg)
              == '0))
    else $error("stalled flag dropped");
endmodule : ubdt_core

// >>> ubdt_host_model.sv
// link-side model offering finished transactions to the descriptor core
`timescale 1ns/10ps
module ubdt_host_model
  import ubdt_pkg::*;
(
  input  wire logic      sys_clk,
  output logic           txn_valid,
  output ubdt_txn_t      txn,
  input  wire logic      txn_ready,
  input  wire ubdt_rsp_t rsp,
  input  wire logic      rsp_valid
);
  // idle at time zero
  initial
  begin
    txn_valid = 1'b0;
    txn       = '0;
  end

  // offer one transaction, hold it until taken, then collect the answer
  task automatic send(input ubdt_txn_t t, output ubdt_rsp_t r,
                      output logic ok);
    int n;
    ok = 1'b0;
    r  = '0;
    n  = 0;
    @(posedge sys_clk);
    txn_valid <= 1'b1;
    txn       <= t;
    // ready is combinational, so look at it where it has settled
    do
    begin
      @(negedge sys_clk);
      n++;
    end while (txn_ready !== 1'b1 && n < 20);
    @(posedge sys_clk);
    // released payload must not keep showing the old value
    txn_valid <= 1'b0;
    txn       <= ~t;
    for (n = 0; n < 20 && !ok; n++)
    begin
      @(negedge sys_clk);
      if (rsp_valid === 1'b1)
      begin
        r  = rsp;
        ok = 1'b1;
      end
    end
  endtask : send
endmodule : ubdt_host_model

// >>> tb.sv
// self-checking bench for the descriptor table core
`timescale 1ns/10ps
module tb
  import ubdt_pkg::*;
;
  logic                   sys_clk;
  logic                   reset;
  logic                   cpu_we;
  logic [UBDT_ADDR_W-1:0] cpu_addr;
  logic [7:0]             cpu_wdata;
  logic [7:0]             cpu_rdata;
  logic [UBDT_NUM_EP-1:0] ep_in_enable;
  logic [UBDT_NUM_EP-1:0] ep_stall_clear;
  logic [UBDT_NUM_EP-1:0] endpoint_stalled_flag;
  logic [UBDT_IDX_W-1:0]  look_idx;
  logic [7:0]             look_status;
  logic                   txn_valid;
  ubdt_txn_t              txn;
  logic                   txn_ready;
  ubdt_rsp_t              rsp;
  logic                   rsp_valid;
  int                     num_errors;
  int                     num_checks;

  ubdt_core u_ubdt_core (.sys_clk(sys_clk), .reset(reset), .cpu_we(cpu_we),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .ep_in_enable(ep_in_enable), .ep_stall_clear(ep_stall_clear),
    .endpoint_stalled_flag(endpoint_stalled_flag), .look_idx(look_idx),
    .look_status(look_status), .txn_valid(txn_valid), .txn(txn),
    .txn_ready(txn_ready), .rsp(rsp), .rsp_valid(rsp_valid));

  ubdt_host_model u_ubdt_host_model (.sys_clk(sys_clk),
    .txn_valid(txn_valid), .txn(txn), .txn_ready(txn_ready), .rsp(rsp),
    .rsp_valid(rsp_valid));

  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  // verdict and end of run
  task automatic wrap_up();
    if (num_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // compare a flag or lookup word
  task automatic chk_val(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val

  // compare a transaction answer
  task automatic chk_rsp(input ubdt_rsp_t e, input ubdt_rsp_t g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD answer expected %h seen %h", e, g);
    end
  endtask : chk_rsp

  // processor byte write, strobe for one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cpu_we    <= 1'b1;
    cpu_addr  <= a;
    cpu_wdata <= d;
    @(posedge sys_clk);
    cpu_we    <= 1'b0;
  endtask : wr

  // read a table byte and compare it
  task automatic chk_mem(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    cpu_addr <= a;
    @(negedge sys_clk);
    chk_val("table byte", {8'h00, e}, {8'h00, cpu_rdata});
  endtask : chk_mem

  // arm a descriptor: count and address first, status byte last
  task automatic arm(input logic [5:0] ix, input logic [7:0] st,
                     input logic [7:0] cn);
    wr({ix, 2'b01}, cn);
    wr({ix, 2'b10}, 8'h00);
    wr({ix, 2'b11}, 8'h05);
    wr({ix, 2'b00}, st);
  endtask : arm

  function automatic ubdt_rsp_t mk(input ubdt_hs_t h, input logic dn,
                                   input logic sl, input logic [3:0] ep);
    mk = '{hs:h, done:dn, stall:sl, ep:ep};
  endfunction : mk

  // send one transaction and judge the answer
  task automatic run(input ubdt_tok_t tk, input logic [3:0] ep,
                     input logic [5:0] ix, input logic [3:0] pid,
                     input logic d1, input logic er, input logic [9:0] n,
                     input ubdt_rsp_t e);
    ubdt_txn_t t;
    ubdt_rsp_t r;
    logic      ok;
    t = '{tok:tk, ep:ep, idx:ix, pid:pid, data1:d1, err:er, count:n};
    u_ubdt_host_model.send(t, r, ok);
    chk_val("taken", 16'h0001, {15'h0, ok});
    chk_rsp(e, r);
  endtask : run

  // disabled endpoint: plain memory, engine refuses it
  task automatic t_ram_mode();
    wr(8'hFC, 8'hA5);
    wr(8'hFF, 8'h3C);
    chk_mem(8'hFF, 8'h3C);
    run(UBDT_TOK_OUT, 4'hF, 6'd63, 4'h1, 1'b0, 1'b0, 10'h001,
        mk(UBDT_HS_NAK, 1'b0, 1'b0, 4'hF));
    chk_mem(8'hFC, 8'hA5);
  endtask : t_ram_mode

  // all four checked toggle rows and two unchecked mismatch rows on an out packet
  task automatic t_toggle();
    logic [2:0] row [6] = '{3'b100, 3'b101, 3'b110, 3'b111, 3'b001,
                            3'b010};
    logic [7:0] st;
    logic       hit;
    for (int i = 0; i < 6; i++)
    begin
      st  = {1'b1, row[i][1], 2'b00, row[i][2], 1'b0, 2'b01};
      hit = !row[i][2] || (row[i][1] == row[i][0]);
      arm(6'd0, st, 8'h40);
      ep_in_enable <= 16'h0009;
      look_idx     <= 6'd0;
      @(negedge sys_clk);
      chk_val("lookup", {8'h00, st}, {8'h00, look_status});
      run(UBDT_TOK_OUT, 4'h0, 6'd0, 4'h1, row[i][0], 1'b0, 10'h2C3,
          mk(UBDT_HS_ACK, hit, 1'b0, 4'h0));
      chk_mem(8'h00, hit ? {1'b0, row[i][1], 4'h1, 2'b10} : st);
      chk_mem(8'h01, hit ? 8'hC3 : 8'h40);
    end
  endtask : t_toggle

  // errored packet, then unchecked processor write into owned memory
  task automatic t_error();
    arm(6'd1, 8'h88, 8'h20);
    run(UBDT_TOK_OUT, 4'h0, 6'd1, 4'h1, 1'b0, 1'b1, 10'h004,
        mk(UBDT_HS_NAK, 1'b0, 1'b0, 4'h0));
    chk_mem(8'h04, 8'h88);
    wr(8'h05, 8'h77);
    chk_mem(8'h05, 8'h77);
  endtask : t_error

  // buffer stall, sticky flag, setup release
  task automatic t_stall();
    arm(6'd6, 8'h84, 8'h10);
    run(UBDT_TOK_IN, 4'h3, 6'd6, 4'h9, 1'b0, 1'b0, 10'h010,
        mk(UBDT_HS_STALL, 1'b0, 1'b1, 4'h3));
    chk_mem(8'h18, 8'h84);
    repeat (5) @(posedge sys_clk);
    chk_val("stalled", 16'h0008, endpoint_stalled_flag);
    ep_stall_clear <= 16'h0008;
    @(posedge sys_clk);
    ep_stall_clear <= 16'h0000;
    @(negedge sys_clk);
    chk_val("stalled", 16'h0000, endpoint_stalled_flag);
    arm(6'd6, 8'h8C, 8'h10);
    run(UBDT_TOK_SETUP, 4'h3, 6'd6, 4'hD, 1'b1, 1'b0, 10'h008,
        mk(UBDT_HS_ACK, 1'b1, 1'b0, 4'h3));
    chk_mem(8'h18, 8'h34);
  endtask : t_stall

  // mid-run reset: engine idles, flags clear, table keeps its bytes
  task automatic t_reset();
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    chk_val("ready", 16'h0001, {15'h0, txn_ready});
    chk_val("rsp valid", 16'h0000, {15'h0, rsp_valid});
    chk_val("stalled", 16'h0000, endpoint_stalled_flag);
    chk_mem(8'h18, 8'h34);
  endtask : t_reset

  // largest count on an in token, then a descriptor no longer owned
  task automatic t_in_max();
    arm(6'd2, 8'h83, 8'hFF);
    run(UBDT_TOK_IN, 4'h0, 6'd2, 4'h9, 1'b0, 1'b0, 10'h3FF,
        mk(UBDT_HS_NONE, 1'b1, 1'b0, 4'h0));
    chk_mem(8'h08, 8'h27);
    chk_mem(8'h09, 8'hFF);
    run(UBDT_TOK_IN, 4'h0, 6'd2, 4'h9, 1'b0, 1'b0, 10'h001,
        mk(UBDT_HS_NAK, 1'b0, 1'b0, 4'h0));
  endtask : t_in_max

  // cut a hang short
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    sys_clk = 1'b0;
    reset = 1'b1;
    cpu_we = 1'b0;
    cpu_addr = 8'h00;
    cpu_wdata = 8'h00;
    ep_in_enable = 16'h0000;
    ep_stall_clear = 16'h0000;
    look_idx = 6'd0;
    num_errors = 0;
    num_checks = 0;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    t_ram_mode();
    t_toggle();
    t_error();
    t_stall();
    t_reset();
    t_in_max();
    wrap_up();
  end
endmodule : tb
